// ### cse_pkg.sv
// Shared constants, types and helpers of the execution block
package cse_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int PADDR_W = 8;
  // Register offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_WDOG = 8'h0C;
  localparam logic [7:0] OFF_DIR = 8'h10;
  localparam logic [7:0] OFF_FADDR = 8'h14;
  localparam logic [7:0] OFF_FDATA = 8'h18;
  // Instruction word fields
  localparam int INSTR_OP_POS = 0;
  localparam int INSTR_DEST_POS = 4;
  localparam int INSTR_FILE_POS = 8;
  localparam int INSTR_LIT_POS = 16;
  // Status word fields
  localparam int ST_C_POS = 0;
  localparam int ST_DC_POS = 1;
  localparam int ST_Z_POS = 2;
  localparam int ST_PD_POS = 3;
  localparam int ST_TO_POS = 4;
  // Direction and watchdog word fields
  localparam int DIR_A_POS = 0;
  localparam int DIR_B_POS = 8;
  localparam int DIR_C_POS = 16;
  localparam int WDOG_CNT_POS = 0;
  localparam int WDOG_PRE_POS = 8;
  // Reset and clear values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] WDOG_PRE_LAST = 8'hFF;
  localparam logic [6:0] FADDR_RST = 7'h00;
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  // Direction-load operand codes
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ROTATE_RIGHT_CARRY,
    OP_SLEEP,
    OP_LITERAL_MINUS_ACC,
    OP_FILE_MINUS_ACC,
    OP_FILE_MINUS_ACC_BORROW,
    OP_NIBBLE_SWAP,
    OP_PIN_DIRECTION_LOAD,
    OP_XOR_LITERAL_ACC
  } cse_op_t;

  typedef struct packed {
    logic [7:0] literal;
    logic [6:0] fileAddr;
    logic dest;
    cse_op_t op;
  } cse_instr_t;

  typedef struct packed {
    logic timeout;
    logic powerdown;
    logic zero;
    logic nibbleCarry;
    logic carry;
  } cse_flags_t;

  typedef struct packed {
    logic [7:0] result;
    logic wrAcc;
    logic wrFile;
    logic wrCarry;
    logic wrNibble;
    logic wrZero;
    logic carry;
    logic nibbleCarry;
    logic zero;
    logic sleep;
    logic [2:0] dirLoad;
  } cse_alu_out_t;

  // a - b - borrowIn, returns {nibble carry, carry, difference}
  function automatic logic [9:0] cse_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic borrowIn);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~borrowIn};
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, ~borrowIn};
    return {lo[4], full[8], full[7:0]};
  endfunction
endpackage

// ### cse_file_ram.sv
// File register storage, flip-flops addressed by index
`timescale 1ns/1ps
module cse_file_ram
  import cse_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [cse_pkg::FADDR_W-1:0] rdAddr,
  output logic [cse_pkg::DATA_W-1:0] rdData,
  input wire logic wrEn,
  input wire logic [cse_pkg::FADDR_W-1:0] wrAddr,
  input wire logic [cse_pkg::DATA_W-1:0] wrData
);
  logic [DATA_W-1:0] mem [FILE_DEPTH];

  assign rdData = mem[rdAddr];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
        mem[i] <= FILE_RST;
      end
    end
    else if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule // cse_file_ram

// ### cse_alu.sv
// Result and flag computation for one instruction
`timescale 1ns/1ps
module cse_alu
  import cse_pkg::*;
(
  input cse_pkg::cse_instr_t instr,
  input wire logic [cse_pkg::DATA_W-1:0] acc,
  input wire logic [cse_pkg::DATA_W-1:0] fileVal,
  input wire logic carryIn,
  output cse_pkg::cse_alu_out_t aluOut
);
  logic [9:0] subLit;
  logic [9:0] subFile;
  logic [9:0] subBorrow;

  assign subLit = cse_sub(instr.literal, acc, 1'b0);
  assign subFile = cse_sub(fileVal, acc, 1'b0);
  assign subBorrow = cse_sub(fileVal, acc, ~carryIn);

  always_comb
  begin
    aluOut = '0;
    unique case (instr.op)
      OP_NOP:
      begin
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        aluOut.result = {carryIn, fileVal[7:1]};
        aluOut.carry = fileVal[0];
        aluOut.wrCarry = 1'b1;
      end
      OP_SLEEP:
      begin
        aluOut.sleep = 1'b1;
      end
      OP_LITERAL_MINUS_ACC:
      begin
        {aluOut.nibbleCarry, aluOut.carry, aluOut.result} = subLit;
        {aluOut.wrCarry, aluOut.wrNibble, aluOut.wrZero} = 3'h7;
      end
      OP_FILE_MINUS_ACC:
      begin
        {aluOut.nibbleCarry, aluOut.carry, aluOut.result} = subFile;
        {aluOut.wrCarry, aluOut.wrNibble, aluOut.wrZero} = 3'h7;
      end
      OP_FILE_MINUS_ACC_BORROW:
      begin
        {aluOut.nibbleCarry, aluOut.carry, aluOut.result} = subBorrow;
        {aluOut.wrCarry, aluOut.wrNibble, aluOut.wrZero} = 3'h7;
      end
      OP_NIBBLE_SWAP:
      begin
        aluOut.result = {fileVal[3:0], fileVal[7:4]};
      end
      OP_PIN_DIRECTION_LOAD:
      begin
        aluOut.dirLoad = {instr.fileAddr == DIR_SEL_C, instr.fileAddr == DIR_SEL_B,
                          instr.fileAddr == DIR_SEL_A};
      end
      OP_XOR_LITERAL_ACC:
      begin
        aluOut.result = acc ^ instr.literal;
        aluOut.wrZero = 1'b1;
      end
      default:
      begin
      end
    endcase
    aluOut.zero = (aluOut.result == 8'h00);
    unique case (instr.op)
      OP_ROTATE_RIGHT_CARRY, OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_BORROW, OP_NIBBLE_SWAP:
      begin
        aluOut.wrAcc = !instr.dest;
        aluOut.wrFile = instr.dest;
      end
      OP_LITERAL_MINUS_ACC, OP_XOR_LITERAL_ACC:
      begin
        aluOut.wrAcc = 1'b1;
      end
      default:
      begin
      end
    endcase
  end
endmodule // cse_alu

// ### cse_exec.sv
// APB-reached execution datapath for rotate, sleep, subtract, swap, direction and xor
`timescale 1ns/1ps
// Summary of operation
// - Rotate file right through carry flag
// - Destination bit picks acc or file
// - Sleep clears power-down flag
// - Sleep sets time-out flag
// - Sleep clears watchdog counter and prescaler
// - Literal minus acc into acc, flags
// - File minus acc to destination, flags
// - File minus acc minus borrow, flags
// - Nibble swap to destination, flags kept
// - Direction load: 5, 6, 7 pick port
// - Xor literal into acc, zero only
module cse_exec
  import cse_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cse_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [cse_pkg::DATA_W-1:0] direction_port_a,
  output logic [cse_pkg::DATA_W-1:0] direction_port_b,
  output logic [cse_pkg::DATA_W-1:0] direction_port_c
);
  import cse_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [DATA_W-1:0] acc;
  cse_flags_t flags;
  logic [DATA_W-1:0] wdCount;
  logic [DATA_W-1:0] wdPre;
  logic [FADDR_W-1:0] fileAddrReg;
  logic [DATA_W-1:0] fileRd;
  cse_instr_t newInstr;
  cse_alu_out_t aluOut;

  wire setupPhase = psel && !penable;
  wire apbWrite = psel && penable && pwrite;
  wire hitInstr = (paddr == OFF_INSTR);
  wire hitAcc = (paddr == OFF_ACC);
  wire hitStatus = (paddr == OFF_STATUS);
  wire hitWdog = (paddr == OFF_WDOG);
  wire hitDir = (paddr == OFF_DIR);
  wire hitFaddr = (paddr == OFF_FADDR);
  wire hitFdata = (paddr == OFF_FDATA);
  wire mapped = hitInstr | hitAcc | hitStatus | hitWdog | hitDir | hitFaddr | hitFdata;
  wire doExec = apbWrite && hitInstr;
  wire wrAccReg = apbWrite && hitAcc;
  wire wrStatus = apbWrite && hitStatus;
  wire wrFaddr = apbWrite && hitFaddr;
  wire wrFdata = apbWrite && hitFdata;

  assign pready = 1'b1;

  assign newInstr.op = cse_op_t'(pwdata[INSTR_OP_POS +: 4]);
  assign newInstr.dest = pwdata[INSTR_DEST_POS];
  assign newInstr.fileAddr = pwdata[INSTR_FILE_POS +: FADDR_W];
  assign newInstr.literal = pwdata[INSTR_LIT_POS +: DATA_W];

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  wire [FADDR_W-1:0] ramRdAddr = doExec ? newInstr.fileAddr : fileAddrReg;
  wire execFileWr = doExec && aluOut.wrFile;
  wire ramWrEn = execFileWr || wrFdata;
  wire [FADDR_W-1:0] ramWrAddr = execFileWr ? newInstr.fileAddr : fileAddrReg;
  wire [DATA_W-1:0] ramWrData = execFileWr ? aluOut.result : pwdata[DATA_W-1:0];

  cse_file_ram u_ram (
    .clk(clk),
    .nrst(nrst),
    .rdAddr(ramRdAddr),
    .rdData(fileRd),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(ramWrData)
  );

  cse_alu u_alu (
    .instr(newInstr),
    .acc(acc),
    .fileVal(fileRd),
    .carryIn(flags.carry),
    .aluOut(aluOut)
  );

  wire execSleep = doExec && aluOut.sleep;
  wire [2:0] dirLoad = doExec ? aluOut.dirLoad : 3'h0;

  // ----------------------------------------
  // Next-state selection
  // ----------------------------------------
  wire [DATA_W-1:0] next_acc = (doExec && aluOut.wrAcc) ? aluOut.result :
                               wrAccReg ? pwdata[DATA_W-1:0] : acc;
  cse_flags_t next_flags;
  always_comb
  begin
    next_flags = flags;
    if (wrStatus)
    begin
      next_flags.carry = pwdata[ST_C_POS];
      next_flags.nibbleCarry = pwdata[ST_DC_POS];
      next_flags.zero = pwdata[ST_Z_POS];
    end
    if (doExec && aluOut.wrCarry)
    begin
      next_flags.carry = aluOut.carry;
    end
    if (doExec && aluOut.wrNibble)
    begin
      next_flags.nibbleCarry = aluOut.nibbleCarry;
    end
    if (doExec && aluOut.wrZero)
    begin
      next_flags.zero = aluOut.zero;
    end
    if (execSleep)
    begin
      next_flags.powerdown = 1'b0;
      next_flags.timeout = 1'b1;
    end
  end

  wire [DATA_W-1:0] next_wdPre = execSleep ? WDOG_CLEAR : DATA_W'(wdPre + 8'h01);
  wire [DATA_W-1:0] next_wdCount = execSleep ? WDOG_CLEAR :
                                   (wdPre == WDOG_PRE_LAST) ? DATA_W'(wdCount + 8'h01) :
                                   wdCount;

  logic [31:0] readMux;
  assign readMux = hitAcc ? {24'h000000, acc} :
                   hitStatus ? {27'h0000000, flags.timeout, flags.powerdown, flags.zero,
                                flags.nibbleCarry, flags.carry} :
                   hitWdog ? {16'h0000, wdPre, wdCount} :
                   hitDir ? {8'h00, direction_port_c, direction_port_b, direction_port_a} :
                   hitFaddr ? {25'h0000000, fileAddrReg} :
                   hitFdata ? {24'h000000, fileRd} : 32'h00000000;

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc <= ACC_RST;
      flags <= '{timeout: TO_RST, powerdown: PD_RST, default: 1'b0};
      wdPre <= WDOG_CLEAR;
      wdCount <= WDOG_CLEAR;
      fileAddrReg <= FADDR_RST;
    end
    else
    begin
      acc <= next_acc;
      flags <= next_flags;
      wdPre <= next_wdPre;
      wdCount <= next_wdCount;
      fileAddrReg <= wrFaddr ? pwdata[FADDR_W-1:0] : fileAddrReg;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      direction_port_a <= DIR_RST;
      direction_port_b <= DIR_RST;
      direction_port_c <= DIR_RST;
    end
    else
    begin
      direction_port_a <= dirLoad[0] ? acc : direction_port_a;
      direction_port_b <= dirLoad[1] ? acc : direction_port_b;
      direction_port_c <= dirLoad[2] ? acc : direction_port_c;
    end
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata <= pwrite ? 32'h00000000 : readMux;
      pslverr <= !mapped;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  wire isOp0 = doExec && !newInstr.dest;

  property p_rotate;
    isOp0 && newInstr.op == OP_ROTATE_RIGHT_CARRY |=>
      acc == {$past(flags.carry), $past(fileRd[7:1])} && flags.carry == $past(fileRd[0]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate result wrong");

  property p_dest_file;
    doExec && newInstr.dest && newInstr.op == OP_FILE_MINUS_ACC |=>
      $stable(acc) && flags.carry == ($past(acc) <= $past(fileRd));
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file dest touched acc");

  property p_sleep_pd;
    execSleep |=> !flags.powerdown;
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("power-down not cleared");

  property p_sleep_to;
    execSleep |=> flags.timeout;
  endproperty
  a_sleep_to: assert property (p_sleep_to) else $error("time-out not set");

  property p_sleep_wdt;
    execSleep |=> wdCount == 8'h00 ##1 wdPre == 8'h01;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared");

  property p_lit_sub;
    doExec && newInstr.op == OP_LITERAL_MINUS_ACC |=>
      acc == 8'($past(newInstr.literal) - $past(acc)) &&
      flags.carry == ($past(acc) <= $past(newInstr.literal)) &&
      flags.nibbleCarry == ($past(acc[3:0]) <= $past(newInstr.literal[3:0]));
  endproperty
  a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");

  property p_file_sub;
    isOp0 && newInstr.op == OP_FILE_MINUS_ACC |=>
      acc == 8'($past(fileRd) - $past(acc)) &&
      flags.nibbleCarry == ($past(acc[3:0]) <= $past(fileRd[3:0]));
  endproperty
  a_file_sub: assert property (p_file_sub) else $error("file subtract wrong");

  property p_borrow_sub;
    isOp0 && newInstr.op == OP_FILE_MINUS_ACC_BORROW |=>
      acc == 8'($past(fileRd) - $past(acc) - {7'h00, !$past(flags.carry)});
  endproperty
  a_borrow_sub: assert property (p_borrow_sub) else $error("borrow subtract wrong");

  property p_swap;
    isOp0 && newInstr.op == OP_NIBBLE_SWAP |=>
      acc == {$past(fileRd[3:0]), $past(fileRd[7:4])} && $stable(flags);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_dir_b;
    doExec && newInstr.op == OP_PIN_DIRECTION_LOAD && newInstr.fileAddr == DIR_SEL_B |=>
      direction_port_b == $past(acc) && $stable(direction_port_a) && $stable(flags);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("direction load wrong");

  property p_xor;
    doExec && newInstr.op == OP_XOR_LITERAL_ACC |=>
      acc == ($past(acc) ^ $past(newInstr.literal)) && $stable(flags.carry) &&
      $stable(flags.nibbleCarry);
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");

  property p_zero;
    doExec && (newInstr.op == OP_XOR_LITERAL_ACC || newInstr.op == OP_LITERAL_MINUS_ACC) |=>
      flags.zero == (acc == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_dir_none;
    doExec && newInstr.op == OP_PIN_DIRECTION_LOAD &&
      (newInstr.fileAddr < DIR_SEL_A || newInstr.fileAddr > DIR_SEL_C) |=>
      $stable(direction_port_a) && $stable(direction_port_b) && $stable(direction_port_c);
  endproperty
  a_dir_none: assert property (p_dir_none) else $error("bad operand loaded port");

  c_sleep: cover property (execSleep);
  c_borrow_in: cover property (doExec && newInstr.op == OP_FILE_MINUS_ACC_BORROW &&
                               !flags.carry);
  c_file_dest: cover property (execFileWr ##[2:8] (setupPhase && hitFdata));
  c_dir_c: cover property (dirLoad[2]);
endmodule // cse_exec

// ### tb.sv
// Self-checking testbench for the execution datapath over APB
`timescale 1ns/1ps
module tb;
  import cse_pkg::*;
  logic clk;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] dirA;
  logic [7:0] dirB;
  logic [7:0] dirC;
  logic lastErr;
  int num_errors = 0;
  int cmp_count = 0;

  cse_exec dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .direction_port_a(dirA), .direction_port_b(dirB), .direction_port_c(dirC));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready high ends this wait after one cycle; the watchdog process can also end it
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask

  task ex(input cse_op_t op, input logic dest, input logic [6:0] f, input logic [7:0] lit);
    wr(OFF_INSTR, {8'h00, lit, 1'b0, f, 3'h0, dest, op});
  endtask

  task setf(input logic [6:0] a, input logic [7:0] v);
    wr(OFF_FADDR, {25'h0, a});
    wr(OFF_FDATA, {24'h0, v});
  endtask

  task getf(input logic [6:0] a, output logic [31:0] r);
    wr(OFF_FADDR, {25'h0, a});
    rd(OFF_FDATA, r);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    logic [31:0] r;
    rd(OFF_STATUS, r);
    chk(r, 32'h18);
    chk({8'h0, dirC, dirB, dirA}, 32'h00FFFFFF);
  endtask

  task rot(input logic [7:0] v, input logic c, input logic dest);
    logic [31:0] r;
    setf(7'h7F, v);
    wr(OFF_STATUS, {31'h0, c});
    wr(OFF_ACC, 32'h11);
    ex(OP_ROTATE_RIGHT_CARRY, dest, 7'h7F, 8'h00);
    getf(7'h7F, r);
    chk(r, dest ? {24'h0, c, v[7:1]} : {24'h0, v});
    rd(OFF_ACC, r);
    chk(r, dest ? 32'h11 : {24'h0, c, v[7:1]});
    rd(OFF_STATUS, r);
    chk(32'(r[0]), 32'(v[0]));
  endtask

  task sub(input cse_op_t op, input logic [7:0] a, input logic [7:0] w, input logic cin,
           input logic dest);
    logic [31:0] r;
    logic [8:0] full;
    logic [4:0] lo;
    logic br;
    br = (op == OP_FILE_MINUS_ACC_BORROW) ? ~cin : 1'b0;
    full = {1'b0, a} - {1'b0, w} - {8'h0, br};
    lo = {1'b0, a[3:0]} - {1'b0, w[3:0]} - {4'h0, br};
    setf(7'h09, a);
    wr(OFF_STATUS, {31'h0, cin});
    wr(OFF_ACC, {24'h0, w});
    ex(op, dest, 7'h09, a);
    rd(OFF_ACC, r);
    chk(r, {24'h0, dest ? w : full[7:0]});
    getf(7'h09, r);
    chk(r, {24'h0, dest ? full[7:0] : a});
    rd(OFF_STATUS, r);
    chk(32'(r[2:0]), {29'h0, full[7:0] == 8'h00, ~lo[4], ~full[8]});
  endtask

  task t_sub;
    logic [7:0] pa [5] = '{8'h05, 8'h06, 8'h21, 8'h00, 8'h80};
    logic [7:0] pw [5] = '{8'h05, 8'h05, 8'h18, 8'h01, 8'h7F};
    for (int i = 0; i < 5; i++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        sub(OP_LITERAL_MINUS_ACC, pa[i], pw[i], c[0], 1'b0);
        sub(OP_FILE_MINUS_ACC, pa[i], pw[i], c[0], c[0]);
        sub(OP_FILE_MINUS_ACC_BORROW, pa[i], pw[i], c[0], ~c[0]);
      end
    end
  endtask

  task t_sleep;
    logic [31:0] r;
    repeat (300) @(posedge clk);
    rd(OFF_WDOG, r);
    chk(32'(r[7:0] != 8'h00), 32'h1);
    ex(OP_SLEEP, 1'b0, 7'h00, 8'h00);
    rd(OFF_WDOG, r);
    chk(32'(r[7:0]), 32'h0);
    chk(32'(r[15:8] < 8'h04), 32'h1);
    rd(OFF_STATUS, r);
    chk(32'(r[4:3]), 32'h2);
  endtask

  task t_swap;
    logic [31:0] r;
    setf(7'h10, 8'h3C);
    wr(OFF_STATUS, 32'h5);
    wr(OFF_ACC, 32'h11);
    ex(OP_NIBBLE_SWAP, 1'b0, 7'h10, 8'h00);
    rd(OFF_ACC, r);
    chk(r, 32'hC3);
    ex(OP_NIBBLE_SWAP, 1'b1, 7'h10, 8'h00);
    getf(7'h10, r);
    chk(r, 32'hC3);
    rd(OFF_STATUS, r);
    chk(32'(r[2:0]), 32'h5);
  endtask

  task t_dir;
    logic [31:0] r;
    logic [7:0] v [3] = '{8'h3C, 8'h5A, 8'h99};
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_ACC, {24'h0, v[i]});
      ex(OP_PIN_DIRECTION_LOAD, 1'b0, 7'(i + 5), 8'h00);
    end
    wr(OFF_STATUS, 32'h0);
    wr(OFF_ACC, 32'h0);
    ex(OP_PIN_DIRECTION_LOAD, 1'b0, 7'h04, 8'h00);
    ex(OP_PIN_DIRECTION_LOAD, 1'b0, 7'h08, 8'h00);
    ex(OP_PIN_DIRECTION_LOAD, 1'b0, 7'h7F, 8'h00);
    chk({8'h0, dirC, dirB, dirA}, 32'h00995A3C);
    rd(OFF_DIR, r);
    chk(r, 32'h00995A3C);
    rd(OFF_STATUS, r);
    chk(32'(r[2:0]), 32'h0);
  endtask

  task t_xor;
    logic [31:0] r;
    wr(OFF_STATUS, 32'h3);
    wr(OFF_ACC, 32'h5A);
    ex(OP_XOR_LITERAL_ACC, 1'b0, 7'h00, 8'h5A);
    rd(OFF_ACC, r);
    chk(r, 32'h0);
    rd(OFF_STATUS, r);
    chk(32'(r[2:0]), 32'h7);
    ex(OP_XOR_LITERAL_ACC, 1'b1, 7'h00, 8'hFF);
    rd(OFF_ACC, r);
    chk(r, 32'hFF);
    rd(OFF_STATUS, r);
    chk(32'(r[2:0]), 32'h3);
  endtask

  task t_bad;
    logic [31:0] r;
    wr(OFF_ACC, 32'h22);
    rd(8'h1C, r);
    chk(r, 32'h0);
    chk(32'(lastErr), 32'h1);
    wr(8'h1C, 32'h33);
    chk(32'(lastErr), 32'h1);
    rd(OFF_ACC, r);
    chk(r, 32'h22);
    chk(32'(lastErr), 32'h0);
  endtask

  task t_rst2;
    logic [31:0] r;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({8'h0, dirC, dirB, dirA}, 32'h00FFFFFF);
    nrst <= 1'b1;
    rd(OFF_STATUS, r);
    chk(r, 32'h18);
  endtask

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    rot(8'hA4, 1'b1, 1'b1);
    rot(8'hA5, 1'b0, 1'b0);
    rot(8'h01, 1'b0, 1'b1);
    t_sub;
    t_sleep;
    t_swap;
    t_dir;
    t_xor;
    t_bad;
    t_rst2;
    test_done;
  end

  initial
  begin
    #1_000_000;
    num_errors++;
    test_done;
  end
endmodule // tb
